// *** apc_audio_port.sv ***
// audio serial port: config registers, clock dividers, serial engine
// Operation
// - clock-out source select, 110/111 both adc
// - m divider power bit gates clock output
// - m ratio 7 bits, zero means 128
// - format field selects i2s dsp rj lj
// - word length 16 20 24 32 bits
// - bit clock direction: input or driven
// - word clock direction: input or driven
// - tristate data out outside the sample bits
// - data offset delays data 0..255 bclks
// - serial loopback routes din to dout
// - converter loopback feeds adc to dac
// - bit clock polarity inverts clock and edges
// - buffer power bit follows codec power
// - bit divider source select, four clocks
// - n divider power bit gates bit clock
// - n ratio 7 bits, zero means 128
`timescale 1ns/1ps
`include "apc_defines.svh"
module apc_audio_port #(
  parameter int SAMPLE_W  = 32,
  parameter int FIFO_DEPTH = `APC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // converter clocks and pins, sampled
  input  wire logic        mclk_i,
  input  wire logic        pll_clk_i,
  input  wire logic        dac_clk_i,
  input  wire logic        dac_modulator_clock_i,
  input  wire logic        adc_clk_i,
  input  wire logic        adc_modulator_clock_i,
  input  wire logic        codec_power_i,
  // serial link pins
  input  wire logic        bclk_i,
  output logic             bclk_o,
  output logic             bclk_oe_o,
  input  wire logic        wclk_i,
  output logic             wclk_o,
  output logic             wclk_oe_o,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  output logic             clock_output_pin_o,
  output logic             buf_power_o,
  // adc samples in, dac samples out
  input  wire logic        adc_valid_i,
  input  wire logic [63:0] adc_data_i,
  output logic             adc_ready_o,
  output logic             dac_valid_o,
  output logic [63:0]      dac_data_o
);
  if (SAMPLE_W != 32) begin : g_bad_width
    $error("sample width must be 32");
  end
  // registers
  logic [7:0] clk_src;
  logic [7:0] clock_output_pin_div;
  logic [7:0] fmt;
  logic [7:0] offset;
  logic [7:0] loopctl;
  logic [7:0] bclk_div;
  logic       rd_pend;
  // avalon slave: one wait cycle then answer
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= (avs_read_i || avs_write_i) && !rd_pend;
    end
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !rd_pend;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      clk_src    <= `APC_RST_CLKSRC;
      clock_output_pin_div <= `APC_RST_CLOCK_OUTPUT_PIN_DIV;
      fmt        <= `APC_RST_FORMAT;
      offset     <= `APC_RST_OFFSET;
      loopctl    <= `APC_RST_LOOP;
      bclk_div   <= `APC_RST_BCLK_DIV;
    end else if (avs_write_i && rd_pend) begin
      unique case (avs_address_i)
        `APC_IDX_CLKSRC:     clk_src    <= avs_writedata_i[7:0] & `APC_MASK_CLKSRC;
        `APC_IDX_CLOCK_OUTPUT_PIN_DIV: clock_output_pin_div <= avs_writedata_i[7:0];
        `APC_IDX_FORMAT:     fmt        <= avs_writedata_i[7:0] & `APC_MASK_FORMAT;
        `APC_IDX_OFFSET:     offset     <= avs_writedata_i[7:0];
        `APC_IDX_LOOP:       loopctl    <= avs_writedata_i[7:0] & `APC_MASK_LOOP;
        `APC_IDX_BCLK_DIV:   bclk_div   <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end
  // pin synchronisers, three stages
  logic [2:0] s_mclk, s_pll, s_dacc, s_dacm, s_adcc, s_adcm, s_bclk, s_wclk, s_din;
  logic       f_mclk, f_pll, f_dacc, f_dacm, f_adcc, f_adcm, f_bclk, f_wclk, f_din;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      {s_mclk, s_pll, s_dacc, s_dacm, s_adcc, s_adcm, s_bclk, s_wclk, s_din} <= '0;
    end else begin
      s_mclk <= {s_mclk[1:0], mclk_i};
      s_pll  <= {s_pll[1:0], pll_clk_i};
      s_dacc <= {s_dacc[1:0], dac_clk_i};
      s_dacm <= {s_dacm[1:0], dac_modulator_clock_i};
      s_adcc <= {s_adcc[1:0], adc_clk_i};
      s_adcm <= {s_adcm[1:0], adc_modulator_clock_i};
      s_bclk <= {s_bclk[1:0], bclk_i};
      s_wclk <= {s_wclk[1:0], wclk_i};
      s_din  <= {s_din[1:0], din_i};
    end
  end
  // filtered levels: change once stages two and three agree
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      {f_mclk, f_pll, f_dacc, f_dacm, f_adcc, f_adcm, f_bclk, f_wclk, f_din} <= '0;
    end else begin
      if (s_mclk[1] == s_mclk[2]) f_mclk <= s_mclk[2];
      if (s_pll[1] == s_pll[2]) f_pll <= s_pll[2];
      if (s_dacc[1] == s_dacc[2]) f_dacc <= s_dacc[2];
      if (s_dacm[1] == s_dacm[2]) f_dacm <= s_dacm[2];
      if (s_adcc[1] == s_adcc[2]) f_adcc <= s_adcc[2];
      if (s_adcm[1] == s_adcm[2]) f_adcm <= s_adcm[2];
      if (s_bclk[1] == s_bclk[2]) f_bclk <= s_bclk[2];
      if (s_wclk[1] == s_wclk[2]) f_wclk <= s_wclk[2];
      if (s_din[1] == s_din[2]) f_din <= s_din[2];
    end
  end
  // source muxes
  logic cdiv_src;
  logic bdiv_src;
  always_comb begin
    unique case (clk_src[2:0])
      3'h0: cdiv_src = f_mclk;
      3'h1: cdiv_src = f_bclk;
      3'h2: cdiv_src = f_din;
      3'h3: cdiv_src = f_pll;
      3'h4: cdiv_src = f_dacc;
      3'h5: cdiv_src = f_dacm;
      default: cdiv_src = f_adcc;
    endcase
    unique case (loopctl[1:0])
      2'h0: bdiv_src = f_dacc;
      2'h1: bdiv_src = f_dacm;
      2'h2: bdiv_src = f_adcc;
      default: bdiv_src = f_adcm;
    endcase
  end
  // dividers: toggle output each half ratio of source rising edges
  logic       cdiv_prev, bdiv_prev, cdiv_out, bdiv_out;
  logic [7:0] cdiv_cnt, bdiv_cnt;
  logic [7:0] m_ratio, n_ratio;
  assign m_ratio = (clock_output_pin_div[6:0] == 7'h00) ? 8'h80 : {1'b0, clock_output_pin_div[6:0]};
  assign n_ratio = (bclk_div[6:0] == 7'h00) ? 8'h80 : {1'b0, bclk_div[6:0]};
  always_ff @(posedge clock_i) begin
    if (srst_i || !clock_output_pin_div[`APC_POS_DIV_PWR]) begin
      cdiv_prev <= 1'b0;
      cdiv_cnt  <= 8'h00;
      cdiv_out  <= 1'b0;
    end else begin
      cdiv_prev <= cdiv_src;
      if (cdiv_src != cdiv_prev) begin
        if (m_ratio == 8'h01) begin
          cdiv_out <= cdiv_src;
        end else if (cdiv_cnt + 8'h01 >= m_ratio) begin
          cdiv_cnt <= 8'h00;
          cdiv_out <= !cdiv_out;
        end else begin
          cdiv_cnt <= cdiv_cnt + 8'h01;
        end
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i || !bclk_div[`APC_POS_DIV_PWR]) begin
      bdiv_prev <= 1'b0;
      bdiv_cnt  <= 8'h00;
      bdiv_out  <= 1'b0;
    end else begin
      bdiv_prev <= bdiv_src;
      if (bdiv_src != bdiv_prev) begin
        if (n_ratio == 8'h01) begin
          bdiv_out <= bdiv_src;
        end else if (bdiv_cnt + 8'h01 >= n_ratio) begin
          bdiv_cnt <= 8'h00;
          bdiv_out <= !bdiv_out;
        end else begin
          bdiv_cnt <= bdiv_cnt + 8'h01;
        end
      end
    end
  end
  // word clock generator: 2 x 32 bit clocks per frame
  logic       bdiv_d, wgen;
  logic [5:0] wcnt;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bdiv_d <= 1'b0;
      wcnt   <= 6'h00;
      wgen   <= 1'b0;
    end else begin
      bdiv_d <= bdiv_out;
      if (bdiv_d && !bdiv_out) begin
        wcnt <= wcnt + 6'h01;
        if (wcnt == 6'h3f) wgen <= 1'b0;
        if (wcnt == 6'h1f) wgen <= 1'b1;
      end
    end
  end
  // active clocks and edges
  logic bclk_act, wclk_act, bclk_prev, wclk_prev, launch, sample;
  assign bclk_act = (fmt[`APC_POS_BCLK_DIR] ? bdiv_out : f_bclk) ^ loopctl[`APC_POS_BCLK_POL];
  assign wclk_act = fmt[`APC_POS_WCLK_DIR] ? wgen : f_wclk;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bclk_prev <= 1'b0;
      wclk_prev <= 1'b0;
    end else begin
      bclk_prev <= bclk_act;
      if (launch) wclk_prev <= wclk_act;
    end
  end
  assign launch = bclk_prev && !bclk_act;
  assign sample = !bclk_prev && bclk_act;
  // frame engine
  logic [5:0]  wl;
  logic [8:0]  start_pos;
  logic [8:0]  pos;
  logic        chan, frame_start;
  logic [31:0] tx_sh, rx_sh;
  logic [31:0] rx_left;
  logic [63:0] tx_word;
  logic        tx_valid, tx_pop, in_data;
  logic        dout_bit;
  always_comb begin
    unique case (fmt[`APC_POS_WLEN_HI:`APC_POS_WLEN_LO])
      2'h0: wl = 6'd16;
      2'h1: wl = 6'd20;
      2'h2: wl = 6'd24;
      default: wl = 6'd32;
    endcase
    unique case (apc_pkg::apc_format_t'(fmt[`APC_POS_FMT_HI:`APC_POS_FMT_LO]))
      apc_pkg::APC_FMT_I2S:             start_pos = 9'd1;
      apc_pkg::APC_FMT_DSP:             start_pos = 9'd0;
      apc_pkg::APC_FMT_RIGHT_JUSTIFIED: start_pos = 9'd32 - {3'b000, wl};
      default:                          start_pos = 9'd0;
    endcase
    start_pos = start_pos + {1'b0, offset};
  end
  assign frame_start = launch && (wclk_act != wclk_prev);
  assign in_data = (pos >= start_pos) && (pos < start_pos + {3'b000, wl});
  assign tx_pop  = frame_start && chan;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pos      <= 9'h000;
      chan     <= 1'b0;
      tx_sh    <= 32'h0;
      dout_bit <= 1'b0;
    end else if (launch) begin
      if (frame_start) begin
        pos   <= 9'h001;
        chan  <= (fmt[7:6] == 2'b01) ? !chan : wclk_act ^ (fmt[7:6] == 2'b00);
        tx_sh <= (wclk_act ^ (fmt[7:6] == 2'b00)) ? tx_word[63:32] : tx_word[31:0];
      end else if (pos != 9'h1ff) begin
        pos <= pos + 9'h001;
      end
      if ((frame_start ? 9'h000 : pos) >= start_pos) begin
        dout_bit <= tx_sh[31];
        tx_sh    <= {tx_sh[30:0], 1'b0};
      end
    end
  end
  // receive: msb first, pairs left then right into a dac sample
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_sh       <= 32'h0;
      rx_left     <= 32'h0;
      dac_valid_o <= 1'b0;
      dac_data_o  <= 64'h0;
    end else begin
      dac_valid_o <= 1'b0;
      if (sample && in_data) rx_sh <= {rx_sh[30:0], f_din};
      if (frame_start && chan) rx_left <= rx_sh;
      if (loopctl[`APC_POS_CONV_LOOP]) begin
        if (tx_pop && tx_valid) begin
          dac_valid_o <= 1'b1;
          dac_data_o  <= tx_word;
        end
      end else if (frame_start && !chan) begin
        dac_valid_o <= 1'b1;
        dac_data_o  <= {rx_left, rx_sh};
      end
    end
  end
  apc_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .in_valid_i  (adc_valid_i),
    .in_data_i   (adc_data_i),
    .in_ready_o  (adc_ready_o),
    .out_valid_o (tx_valid),
    .out_data_o  (tx_word),
    .out_ready_i (tx_pop)
  );
  // pins and status outputs, all registered
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bclk_o             <= 1'b0;
      bclk_oe_o          <= 1'b0;
      wclk_o             <= 1'b0;
      wclk_oe_o          <= 1'b0;
      dout_o             <= 1'b0;
      dout_oe_o          <= 1'b0;
      clock_output_pin_o <= 1'b0;
      buf_power_o        <= 1'b0;
    end else begin
      bclk_o             <= bclk_act;
      bclk_oe_o          <= fmt[`APC_POS_BCLK_DIR];
      wclk_o             <= wgen;
      wclk_oe_o          <= fmt[`APC_POS_WCLK_DIR];
      dout_o             <= loopctl[`APC_POS_SER_LOOP] ? f_din : dout_bit;
      dout_oe_o          <= !fmt[`APC_POS_TRISTATE] || in_data;
      clock_output_pin_o <= cdiv_out;
      buf_power_o        <= !loopctl[`APC_POS_BUF_PWR] || codec_power_i;
    end
  end
  // register read-back
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && !rd_pend) begin
      unique case (avs_address_i)
        `APC_IDX_CLKSRC:     avs_readdata_o <= {24'h0, clk_src};
        `APC_IDX_CLOCK_OUTPUT_PIN_DIV: avs_readdata_o <= {24'h0, clock_output_pin_div};
        `APC_IDX_FORMAT:     avs_readdata_o <= {24'h0, fmt};
        `APC_IDX_OFFSET:     avs_readdata_o <= {24'h0, offset};
        `APC_IDX_LOOP:       avs_readdata_o <= {24'h0, loopctl};
        `APC_IDX_BCLK_DIV:   avs_readdata_o <= {24'h0, bclk_div};
        `APC_IDX_STATUS:     avs_readdata_o <= {28'h0, bclk_oe_o, wclk_oe_o, tx_valid, chan};
        default:             avs_readdata_o <= 32'h0;
      endcase
    end
  end
endmodule // apc_audio_port

// *** apc_audio_port_monitor.sv ***
// checker of bus handshake, clock pins and pulses of the audio port
`timescale 1ns/1ps
`include "apc_defines.svh"
module apc_audio_port_monitor (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        srst_i,
  // watched ports
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        bclk_o,
  input wire logic        bclk_oe_o,
  input wire logic        wclk_oe_o,
  input wire logic        clock_output_pin_o,
  input wire logic        dac_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // shadow of written settings and cycles since each write
  logic [7:0] fmt, mdiv, ndiv;
  logic [3:0] f_age, m_age, n_age;
  wire        wr = avs_write_i && !avs_waitrequest_o;
  wire        rd = avs_read_i && !avs_waitrequest_o;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fmt <= 8'h00;
      mdiv <= 8'h01;
      ndiv <= 8'h01;
      f_age <= 4'hf;
      m_age <= 4'hf;
      n_age <= 4'hf;
    end else begin
      f_age <= (wr && avs_address_i == `APC_IDX_FORMAT) ? 4'h0 : f_age + 4'(f_age != 4'hf);
      m_age <= (wr && avs_address_i == `APC_IDX_CLOCK_OUTPUT_PIN_DIV) ? 4'h0 : m_age + 4'(m_age != 4'hf);
      n_age <= (wr && avs_address_i == `APC_IDX_BCLK_DIV) ? 4'h0 : n_age + 4'(n_age != 4'hf);
      if (wr && avs_address_i == `APC_IDX_FORMAT) fmt <= avs_writedata_i[7:0];
      if (wr && avs_address_i == `APC_IDX_CLOCK_OUTPUT_PIN_DIV) mdiv <= avs_writedata_i[7:0];
      if (wr && avs_address_i == `APC_IDX_BCLK_DIV) ndiv <= avs_writedata_i[7:0];
    end
  end
  sequence s_grant;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  chk_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> s_grant)
    else $error("waitrequest not high for one cycle");
  chk_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  chk_unmapped_zero: assert property (rd && (avs_address_i < 8'h19 || avs_address_i > 8'h1f)
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  chk_src_reserved: assert property (
    rd && avs_address_i == `APC_IDX_CLKSRC |-> avs_readdata_o[31:3] == 29'h0)
    else $error("source select reserved bits set");
  chk_fmt_reserved: assert property (
    rd && avs_address_i == `APC_IDX_FORMAT |-> avs_readdata_o[1] == 1'b0)
    else $error("format reserved bit set");
  chk_clk_dir: assert property (f_age > 4'd5 |-> {bclk_oe_o, wclk_oe_o} == fmt[3:2])
    else $error("clock direction differs from setting");
  chk_mdiv_off: assert property (m_age > 4'd5 && !mdiv[7] |-> !clock_output_pin_o)
    else $error("clock output while divider off");
  chk_ndiv_off: assert property (n_age > 4'd5 && !ndiv[7] && f_age > 4'd5 && fmt[3]
    |=> $stable(bclk_o)) else $error("bit clock moves while divider off");
  chk_dac_pulse: assert property (dac_valid_o |=> !dac_valid_o)
    else $error("dac valid longer than one cycle");
endmodule // apc_audio_port_monitor

// *** apc_defines.svh ***
// register offsets, fields and reset values of the audio port clock block
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH
`define APC_IDX_CLKSRC      8'h19
`define APC_IDX_CLOCK_OUTPUT_PIN_DIV  8'h1a
`define APC_IDX_FORMAT      8'h1b
`define APC_IDX_OFFSET      8'h1c
`define APC_IDX_LOOP        8'h1d
`define APC_IDX_BCLK_DIV    8'h1e
`define APC_IDX_STATUS      8'h1f
`define APC_RST_CLKSRC      8'h00
`define APC_RST_CLOCK_OUTPUT_PIN_DIV  8'h01
`define APC_RST_FORMAT      8'h00
`define APC_RST_OFFSET      8'h00
`define APC_RST_LOOP        8'h00
`define APC_RST_BCLK_DIV    8'h01
`define APC_MASK_CLKSRC     8'h07
`define APC_MASK_FORMAT     8'hfd
`define APC_MASK_LOOP       8'h3f
`define APC_POS_DIV_PWR     7
`define APC_POS_FMT_HI      7
`define APC_POS_FMT_LO      6
`define APC_POS_WLEN_HI     5
`define APC_POS_WLEN_LO     4
`define APC_POS_BCLK_DIR    3
`define APC_POS_WCLK_DIR    2
`define APC_POS_TRISTATE    0
`define APC_POS_SER_LOOP    5
`define APC_POS_CONV_LOOP   4
`define APC_POS_BCLK_POL    3
`define APC_POS_BUF_PWR     2
`define APC_FIFO_DEPTH      16
`endif

// *** apc_fifo.sv ***
// parameterised valid/ready sample fifo
`timescale 1ns/1ps
module apc_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // apc_fifo

// *** apc_link_host.sv ***
// host side of the serial link: clock master, i2s frames, gap between frames
`timescale 1ns/1ps
module apc_link_host (
  // clock and control
  input  wire logic        clock_i,
  input  wire logic        run_i,
  input  wire logic [31:0] word_i,
  // link pins
  output logic             bclk_o,
  output logic             wclk_o,
  output logic             din_o,
  output logic             busy_o
);
  logic [10:0] cnt = 11'h0;
  logic        junk = 1'b0;
  wire  [5:0]  slot = cnt[9:4];
  wire  [4:0]  pos = 5'd31 - slot[4:0] + 5'd1;
  // frame of 64 bit clocks, then a gap with bclk low, wclk high and din toggling junk, stops only on a boundary
  always @(posedge clock_i) begin
    if (run_i || cnt != 11'h0) cnt <= cnt + 11'h1;
    junk <= ~junk;
  end
  assign busy_o = !cnt[10] && (run_i || cnt != 11'h0);
  assign bclk_o = busy_o ? cnt[3] : 1'b0;
  assign wclk_o = busy_o ? cnt[9] : 1'b1;
  assign din_o = busy_o ? word_i[pos] : junk;
endmodule // apc_link_host

// *** apc_pkg.sv ***
// types of the audio port clock block
package apc_pkg;
  typedef enum logic [1:0] {
    APC_FMT_I2S,
    APC_FMT_DSP,
    APC_FMT_RIGHT_JUSTIFIED,
    APC_FMT_LEFT_JUSTIFIED
  } apc_format_t;
  typedef enum logic [1:0] {
    APC_PH_IDLE,
    APC_PH_OFFSET,
    APC_PH_SHIFT,
    APC_PH_DONE
  } apc_phase_t;
endpackage

// *** test_apc_audio_port.sv ***
// self-checking bench of the audio port clock block
`timescale 1ns/1ps
`include "apc_defines.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module test_apc_audio_port;
  logic        clock_i = 0, srst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [7:0]  avs_address_i = 0, cyc = 0;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o;
  logic        avs_waitrequest_o, bclk_o, bclk_oe_o, wclk_o, wclk_oe_o, dout_o, dout_oe_o;
  logic        clock_output_pin_o, buf_power_o, adc_ready_o, dac_valid_o, din_i;
  logic        adc_valid_i = 0, codec_power_i = 1, run = 0, h_bclk, h_wclk, h_busy;
  logic [63:0] adc_data_i = 0, dac_data_o;
  int          err_total = 0, n_tests = 0;
  wire mclk_i = cyc[2], pll_clk_i = cyc[3], dac_clk_i = cyc[2];
  wire dac_modulator_clock_i = cyc[3], adc_clk_i = cyc[4], adc_modulator_clock_i = cyc[5];
  wire bclk_i = (bclk_oe_o === 1'b1) ? bclk_o : h_bclk;
  wire wclk_i = (wclk_oe_o === 1'b1) ? wclk_o : h_wclk;
  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 8'h1;
  apc_link_host u_host (.clock_i, .run_i(run), .word_i(32'hc3a5_0f69), .bclk_o(h_bclk),
    .wclk_o(h_wclk), .din_o(din_i), .busy_o(h_busy));
  apc_audio_port DUT (.clock_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .mclk_i, .pll_clk_i, .dac_clk_i,
    .dac_modulator_clock_i, .adc_clk_i, .adc_modulator_clock_i, .codec_power_i, .bclk_i,
    .bclk_o, .bclk_oe_o, .wclk_i, .wclk_o, .wclk_oe_o, .din_i, .dout_o, .dout_oe_o,
    .clock_output_pin_o, .buf_power_o, .adc_valid_i, .adc_data_i, .adc_ready_o,
    .dac_valid_o, .dac_data_o);
  task automatic bus(input logic w, input logic [7:0] a, d, output logic [31:0] q);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin @(posedge clock_i); end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 0;
    avs_read_i <= 0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, e);
    logic [31:0] q;
    bus(0, a, 8'h0, q);
    `CHK(nm, {24'h0, e}, q)
  endtask
  task automatic edges(input logic sel, input int e);
    logic p, s;
    int n;
    n = 0;
    p = 1;
    repeat (256) begin
      @(posedge clock_i);
      s = sel ? bclk_o : clock_output_pin_o;
      if (s === 1'b1 && !p) n++;
      p = (s === 1'b1);
    end
    `CHK("edges", 1'b1, (n >= e - 1 && n <= e + 1))
  endtask
  task t_regs;
    logic [7:0] t [7][3] = '{'{8'h05, 8'h00, 8'h00}, '{`APC_IDX_BCLK_DIV, 8'h01, 8'hff},
      '{`APC_IDX_CLKSRC, 8'h00, 8'h07}, '{`APC_IDX_CLOCK_OUTPUT_PIN_DIV, 8'h01, 8'hff},
      '{`APC_IDX_FORMAT, 8'h00, 8'hfd}, '{`APC_IDX_OFFSET, 8'h00, 8'hff},
      '{`APC_IDX_LOOP, 8'h00, 8'h3f}};
    foreach (t[i]) begin
      rdc("reset", t[i][0], t[i][1]);
      wr(t[i][0], t[i][2]);
      rdc("masked", t[i][0], t[i][2]);
    end
    repeat (8) @(posedge clock_i);
    `CHK("oe", 2'b11, {bclk_oe_o, wclk_oe_o})
    wr(`APC_IDX_LOOP, 8'h00);
    wr(`APC_IDX_FORMAT, 8'h00);
    repeat (8) @(posedge clock_i);
    `CHK("oe", 2'b00, {bclk_oe_o, wclk_oe_o})
  endtask
  task t_clock_output_pin;
    int c [6] = '{0, 3, 4, 5, 6, 7};
    int p [6] = '{8, 16, 8, 16, 32, 32};
    wr(`APC_IDX_CLOCK_OUTPUT_PIN_DIV, 8'h81);
    foreach (c[i]) begin
      wr(`APC_IDX_CLKSRC, 8'(c[i]));
      edges(0, 256 / p[i]);
    end
    wr(`APC_IDX_CLKSRC, 8'h00);
    wr(`APC_IDX_CLOCK_OUTPUT_PIN_DIV, 8'h82);
    edges(0, 16);
    wr(`APC_IDX_CLOCK_OUTPUT_PIN_DIV, 8'h02);
    edges(0, 0);
  endtask
  task t_bclk;
    wr(`APC_IDX_FORMAT, 8'h08);
    wr(`APC_IDX_BCLK_DIV, 8'h81);
    for (int s = 0; s < 4; s++) begin
      wr(`APC_IDX_LOOP, 8'(s));
      edges(1, 32 >> s);
    end
    wr(`APC_IDX_LOOP, 8'h00);
    wr(`APC_IDX_BCLK_DIV, 8'h82);
    edges(1, 16);
    wr(`APC_IDX_BCLK_DIV, 8'h02);
    edges(1, 0);
    wr(`APC_IDX_FORMAT, 8'h00);
  endtask
  task t_fifo;
    int k, w;
    k = 0;
    wr(`APC_IDX_LOOP, 8'h10);
    repeat (20) begin
      adc_valid_i <= 1;
      adc_data_i <= {32'ha0000000 + k, 32'hb0000000 + k};
      @(posedge clock_i);
      if (adc_ready_o === 1'b1) k++;
    end
    adc_valid_i <= 0;
    `CHK("fill", 16, k)
    run <= 1;
    for (int j = 0; j < 16; j++) begin
      w = 0;
      do begin @(posedge clock_i); w++; end while (dac_valid_o !== 1'b1 && w < 4000);
      `CHK("dac", {32'ha0000000 + j, 32'hb0000000 + j}, dac_data_o)
    end
    `CHK("drained", 1'b1, adc_ready_o)
  endtask
  task t_loop;
    logic [7:0] dh, bh, ok;
    ok = 8'hff;
    dh = 0;
    bh = 0;
    wr(`APC_IDX_LOOP, 8'h20);
    repeat (3000) begin
      @(posedge clock_i);
      for (int k = 1; k < 8; k++) if (&bh && dout_o !== dh[k]) ok[k] = 0;
      dh = {dh[6:0], din_i};
      bh = {bh[6:0], h_busy};
    end
    `CHK("loop", 1'b1, |ok[7:1])
    wr(`APC_IDX_LOOP, 8'h00);
  endtask
  task t_tri;
    int lo [2];
    for (int b = 0; b < 2; b++) begin
      wr(`APC_IDX_FORMAT, 8'(b));
      lo[b] = 0;
      repeat (2048) @(posedge clock_i) if (h_busy && dout_oe_o !== 1'b1) lo[b]++;
    end
    `CHK("held", 1'b1, lo[0] < 64)
    `CHK("float", 1'b1, lo[1] > 0)
  endtask
  task t_misc;
    int n;
    logic p;
    n = 0;
    p = 1;
    wr(`APC_IDX_BCLK_DIV, 8'h81);
    wr(`APC_IDX_FORMAT, 8'h0c);
    repeat (2048) begin
      @(posedge clock_i);
      if (wclk_o === 1'b1 && !p) n++;
      p = (wclk_o === 1'b1);
    end
    `CHK("wclk", 1'b1, (n >= 3 && n <= 5))
    wr(`APC_IDX_BCLK_DIV, 8'h02);
    wr(`APC_IDX_FORMAT, 8'h00);
    wr(`APC_IDX_LOOP, 8'h0c);
    wr(`APC_IDX_FORMAT, 8'h08);
    codec_power_i <= 0;
    repeat (8) @(posedge clock_i);
    `CHK("pol", 1'b1, bclk_o)
    `CHK("bufoff", 1'b0, buf_power_o)
    wr(`APC_IDX_FORMAT, 8'h00);
    wr(`APC_IDX_LOOP, 8'h00);
    repeat (8) @(posedge clock_i);
    `CHK("bufon", 1'b1, buf_power_o)
    codec_power_i <= 1;
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    srst_i <= 0;
    t_regs;
    t_clock_output_pin;
    t_bclk;
    t_fifo;
    t_loop;
    t_tri;
    t_misc;
    print_verdict;
  end
  initial begin
    #3200000;
    err_total++;
    print_verdict;
  end
endmodule // test_apc_audio_port
bind apc_audio_port apc_audio_port_monitor u_mon (.clock_i, .srst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .bclk_o, .bclk_oe_o, .wclk_oe_o, .clock_output_pin_o, .dac_valid_o);
